/* File: design/ser_status_event.sv */
/*
 * standard event flags with mask, pending-operation tracking, and two
 * five-register status groups feeding the status byte summary bits.
 * assumes condition inputs come from outside the clock domain; all event
 * strobes and commands come from logic on mclk and last one cycle.
 */
`timescale 1ns/1ns

// ---------------------------------------------------------------
// one status group: filters, sticky events, enable mask
// ---------------------------------------------------------------
module ser_status_group (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic ce,
    // synchronised live condition
    input wire logic [15:0] cond,
    // register access strobes
    input wire logic [15:0] wdata,
    input wire logic ptrWr,
    input wire logic ntrWr,
    input wire logic enWr,
    input wire logic evRd,
    input wire logic clrStat,
    input wire logic preset,
    // register contents
    output logic [15:0] ptr_q,
    output logic [15:0] ntr_q,
    output logic [15:0] en_q,
    output logic [15:0] ev_q,
    output logic summary
);
    logic [15:0] condPrev_q;
    logic [15:0] hit;

    // edge selection through filters
    assign hit = ((ptr_q & cond & ~condPrev_q) | (ntr_q & ~cond & condPrev_q))
        & ser_pkg::GRP_MASK;
    assign summary = |(ev_q & en_q);

    // previous condition for edge detect
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            condPrev_q <= 16'h0000;
        end else if (ce) begin
            condPrev_q <= cond;
        end
    end

    // transition filters, untouched by clear or reads
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ptr_q <= ser_pkg::PTR_DFLT;
            ntr_q <= ser_pkg::NTR_DFLT;
        end else if (ce) begin
            if (preset) begin
                ptr_q <= ser_pkg::PTR_DFLT;
                ntr_q <= ser_pkg::NTR_DFLT;
            end else begin
                if (ptrWr) begin
                    ptr_q <= wdata & ser_pkg::GRP_MASK;
                end
                if (ntrWr) begin
                    ntr_q <= wdata & ser_pkg::GRP_MASK;
                end
            end
        end
    end

    // enable mask
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            en_q <= ser_pkg::EN_RST;
        end else if (ce) begin
            if (preset) begin
                en_q <= ser_pkg::EN_RST;
            end else if (enWr) begin
                en_q <= wdata & ser_pkg::GRP_MASK;
            end
        end
    end

    // sticky events; a new hit beats the clear
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ev_q <= 16'h0000;
        end else if (ce) begin
            ev_q <= ((evRd || clrStat) ? 16'h0000 : ev_q) | hit;
        end
    end
endmodule

// ---------------------------------------------------------------
// top: standard event flags and both groups
// ---------------------------------------------------------------
module ser_status_event (
    // clock, reset, enable
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic ce,
    // controller commands
    input wire logic cmdValid,
    input wire ser_pkg::ser_cmd_e cmdCode,
    input wire logic [15:0] cmdData,
    output logic rspValid,
    output logic [15:0] rspData,
    // measurement sequencing
    input wire logic autoTrigCount,
    input wire logic statsEnable,
    input wire logic totalizeOrPeaks,
    input wire logic measStart,
    input wire logic measCycleEnd,
    input wire logic blockStart,
    input wire logic blockLastDone,
    // error reporting
    input wire logic errValid,
    input wire logic signed [15:0] errCode,
    input wire logic queueEmptyRead,
    input wire logic queueDataLost,
    input wire logic syntaxError,
    input wire logic unknownCommand,
    input wire logic triggerInMessage,
    input wire logic internalFault,
    input wire logic paramError,
    // live conditions from pins
    input wire logic [15:0] operCondIn,
    input wire logic [15:0] quesCondIn,
    // status byte summary bits and pending flag
    output logic questionable_summary,
    output logic standard_event_summary,
    output logic operation_summary,
    output logic pending
);
    logic [7:0] standard_event_flags_q;
    logic [7:0] eventMask_q;
    logic doneArmed_q;
    logic [15:0] opMeta_q;
    logic [15:0] opSync_q;
    logic [15:0] qsMeta_q;
    logic [15:0] qsSync_q;
    logic [15:0] opPtr;
    logic [15:0] opNtr;
    logic [15:0] opEn;
    logic [15:0] opEv;
    logic [15:0] qsPtr;
    logic [15:0] qsNtr;
    logic [15:0] qsEn;
    logic [15:0] qsEv;
    logic opSum;
    logic qsSum;
    logic blockMode;
    logic pendRise;
    logic pendFall;
    logic pending_d;
    logic doneNow;
    logic [7:0] flagSet;
    logic [7:0] flags_d;
    logic isCmd;
    logic [15:0] rsp_d;

    // ---------------------------------------------------------------
    // condition synchronisers
    // ---------------------------------------------------------------
    // two flops before any use
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            opMeta_q <= 16'h0000;
            opSync_q <= 16'h0000;
            qsMeta_q <= 16'h0000;
            qsSync_q <= 16'h0000;
        end else if (ce) begin
            opMeta_q <= operCondIn;
            opSync_q <= opMeta_q & ser_pkg::GRP_MASK;
            qsMeta_q <= quesCondIn;
            qsSync_q <= qsMeta_q & ser_pkg::GRP_MASK;
        end
    end

    // ---------------------------------------------------------------
    // status groups
    // ---------------------------------------------------------------
    assign isCmd = cmdValid;

    // operation group, five registers
    ser_status_group uOper (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .ce(ce),
        .cond(opSync_q),
        .wdata(cmdData),
        .ptrWr(isCmd && cmdCode == ser_pkg::CMD_OP_PTR_WR),
        .ntrWr(isCmd && cmdCode == ser_pkg::CMD_OP_NTR_WR),
        .enWr(isCmd && cmdCode == ser_pkg::CMD_OP_EN_WR),
        .evRd(isCmd && cmdCode == ser_pkg::CMD_OP_EV_RD),
        .clrStat(isCmd && cmdCode == ser_pkg::CMD_CLS),
        .preset(isCmd && cmdCode == ser_pkg::CMD_PRESET),
        .ptr_q(opPtr),
        .ntr_q(opNtr),
        .en_q(opEn),
        .ev_q(opEv),
        .summary(opSum)
    );

    // questionable group, five registers
    ser_status_group uQues (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .ce(ce),
        .cond(qsSync_q),
        .wdata(cmdData),
        .ptrWr(isCmd && cmdCode == ser_pkg::CMD_QS_PTR_WR),
        .ntrWr(isCmd && cmdCode == ser_pkg::CMD_QS_NTR_WR),
        .enWr(isCmd && cmdCode == ser_pkg::CMD_QS_EN_WR),
        .evRd(isCmd && cmdCode == ser_pkg::CMD_QS_EV_RD),
        .clrStat(isCmd && cmdCode == ser_pkg::CMD_CLS),
        .preset(isCmd && cmdCode == ser_pkg::CMD_PRESET),
        .ptr_q(qsPtr),
        .ntr_q(qsNtr),
        .en_q(qsEn),
        .ev_q(qsEv),
        .summary(qsSum)
    );

    // ---------------------------------------------------------------
    // pending operation and completion
    // ---------------------------------------------------------------
    // block mode only with auto count, statistics, plain function
    assign blockMode = autoTrigCount && statsEnable && !totalizeOrPeaks;
    assign pendRise = blockMode ? blockStart : measStart;
    assign pendFall = blockMode ? blockLastDone : measCycleEnd;
    assign pending_d = pendRise ? 1'b1 : (pendFall ? 1'b0 : pending);
    assign doneNow = isCmd && cmdCode == ser_pkg::CMD_DONE && !pending;

    // pending flag
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            pending <= 1'b0;
        end else if (ce) begin
            pending <= pending_d;
        end
    end

    // completion armed while work is pending
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            doneArmed_q <= 1'b0;
        end else if (ce) begin
            if (isCmd && cmdCode == ser_pkg::CMD_DONE && pending) begin
                doneArmed_q <= 1'b1;
            end else if (pending && !pending_d) begin
                doneArmed_q <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // standard event flags
    // ---------------------------------------------------------------
    // event sources into flag positions
    always_comb begin
        flagSet = 8'h00;
        flagSet[ser_pkg::DONE_BIT] = doneNow || (doneArmed_q && pending && !pending_d);
        flagSet[ser_pkg::QUERY_BIT] = queueEmptyRead || queueDataLost
            || (errValid && errCode >= ser_pkg::QUERY_LO && errCode <= ser_pkg::QUERY_HI);
        flagSet[ser_pkg::DEVICE_BIT] = internalFault || (errValid
            && (errCode >= ser_pkg::DEVICE_POS
            || (errCode >= ser_pkg::DEVICE_LO && errCode <= ser_pkg::DEVICE_HI)));
        flagSet[ser_pkg::RUN_BIT] = paramError
            || (errValid && errCode >= ser_pkg::RUN_LO && errCode <= ser_pkg::RUN_HI);
        flagSet[ser_pkg::CMDERR_BIT] = syntaxError || unknownCommand || triggerInMessage
            || (errValid && errCode >= ser_pkg::CMDERR_LO && errCode <= ser_pkg::CMDERR_HI);
        flags_d = standard_event_flags_q;
        if (isCmd && (cmdCode == ser_pkg::CMD_FLAGS_RD || cmdCode == ser_pkg::CMD_CLS)) begin
            flags_d = 8'h00;
        end
        flags_d = (flags_d | flagSet) & ser_pkg::FLAGS_MASK;
    end

    // flags; reset is power-up, so power-on flag starts set
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            standard_event_flags_q <= ser_pkg::FLAGS_RST;
        end else if (ce) begin
            standard_event_flags_q <= flags_d;
        end
    end

    // event mask
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            eventMask_q <= ser_pkg::ESE_RST;
        end else if (ce && isCmd && cmdCode == ser_pkg::CMD_ESE_WR) begin
            eventMask_q <= cmdData[7:0];
        end
    end

    // ---------------------------------------------------------------
    // status byte summaries
    // ---------------------------------------------------------------
    // registered summary bits
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            standard_event_summary <= 1'b0;
            questionable_summary <= 1'b0;
            operation_summary <= 1'b0;
        end else if (ce) begin
            standard_event_summary <= |(standard_event_flags_q & eventMask_q);
            questionable_summary <= qsSum;
            operation_summary <= opSum;
        end
    end

    // ---------------------------------------------------------------
    // query answers
    // ---------------------------------------------------------------
    // read mux; values before any clear
    always_comb begin
        rsp_d = 16'h0000;
        case (cmdCode)
            ser_pkg::CMD_FLAGS_RD: rsp_d = {8'h00, standard_event_flags_q};
            ser_pkg::CMD_ESE_RD: rsp_d = {8'h00, eventMask_q};
            ser_pkg::CMD_OP_COND_RD: rsp_d = opSync_q;
            ser_pkg::CMD_OP_EV_RD: rsp_d = opEv;
            ser_pkg::CMD_OP_PTR_RD: rsp_d = opPtr;
            ser_pkg::CMD_OP_NTR_RD: rsp_d = opNtr;
            ser_pkg::CMD_OP_EN_RD: rsp_d = opEn;
            ser_pkg::CMD_QS_COND_RD: rsp_d = qsSync_q;
            ser_pkg::CMD_QS_EV_RD: rsp_d = qsEv;
            ser_pkg::CMD_QS_PTR_RD: rsp_d = qsPtr;
            ser_pkg::CMD_QS_NTR_RD: rsp_d = qsNtr;
            ser_pkg::CMD_QS_EN_RD: rsp_d = qsEn;
            default: rsp_d = 16'h0000;
        endcase
    end

    // answer registered one cycle after command
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rspValid <= 1'b0;
            rspData <= 16'h0000;
        end else if (ce) begin
            rspValid <= isCmd;
            rspData <= isCmd ? rsp_d : 16'h0000;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    a_unused_bits_zero:
        assert property (standard_event_flags_q[1] == 1'b0 && standard_event_flags_q[6] == 1'b0)
        else $error("unused flag bits not zero");
    a_flags_read_clear:
        assert property (ce && isCmd && cmdCode == ser_pkg::CMD_FLAGS_RD && flagSet == 8'h00
            |=> standard_event_flags_q == 8'h00 && rspData[7:0] == $past(standard_event_flags_q))
        else $error("flag read did not return and clear");
    a_done_at_once:
        assert property (ce && doneNow |=> standard_event_flags_q[ser_pkg::DONE_BIT])
        else $error("completion flag not set at once");
    a_done_on_fall:
        assert property (ce && doneArmed_q && pending && !pending_d
            && !(isCmd && cmdCode == ser_pkg::CMD_DONE)
            |=> standard_event_flags_q[ser_pkg::DONE_BIT] && !doneArmed_q)
        else $error("completion flag not set on pending fall");
    a_done_waits:
        assert property (ce && doneArmed_q && pending_d && !doneNow
            && !(isCmd && cmdCode == ser_pkg::CMD_FLAGS_RD)
            && !standard_event_flags_q[ser_pkg::DONE_BIT]
            |=> !standard_event_flags_q[ser_pkg::DONE_BIT])
        else $error("completion flag set while still pending");
    a_block_pending:
        assert property (ce && blockMode && blockStart ##1 (ce && !blockLastDone && !pendFall)
            |=> pending)
        else $error("block pending dropped early");
    a_query_class:
        assert property (ce && errValid && errCode == ser_pkg::QUERY_HI
            |=> standard_event_flags_q[ser_pkg::QUERY_BIT])
        else $error("query error code not flagged");
    a_esb_summary:
        assert property (ce |=> standard_event_summary
            == |($past(standard_event_flags_q) & $past(eventMask_q)))
        else $error("standard summary mismatch");
    a_filter_hold:
        assert property (ce && isCmd && cmdCode == ser_pkg::CMD_CLS |=> $stable(opPtr)
            && $stable(qsNtr))
        else $error("filters changed on clear");
    a_event_sticky:
        assert property (ce && opEv[0] && !(isCmd && (cmdCode == ser_pkg::CMD_OP_EV_RD
            || cmdCode == ser_pkg::CMD_CLS)) |=> opEv[0])
        else $error("event bit dropped without read");
    a_oper_summary:
        assert property (ce |=> operation_summary == |($past(opEv) & $past(opEn)))
        else $error("operation summary mismatch");

    c_done_deferred: cover property (doneArmed_q ##[1:20] standard_event_flags_q[0]);
    c_flags_read: cover property (isCmd && cmdCode == ser_pkg::CMD_FLAGS_RD && rsp_d != 16'h0000);
    c_oper_event: cover property (operation_summary);
    c_set_clear_tie: cover property (isCmd && cmdCode == ser_pkg::CMD_OP_EV_RD && opEv != 0
        && uOper.hit != 16'h0000);
endmodule

/* File: design/ser_pkg.sv */
/*
 * constants, command codes and field layout for the status event block.
 * assumes one clock domain and a controller that issues one command per strobe.
 */
package ser_pkg;
    // ---------------------------------------------------------------
    // flag positions and reset values
    // ---------------------------------------------------------------
    localparam int DONE_BIT = 0;
    localparam int QUERY_BIT = 2;
    localparam int DEVICE_BIT = 3;
    localparam int RUN_BIT = 4;
    localparam int CMDERR_BIT = 5;
    localparam int POWER_BIT = 7;
    localparam logic [7:0] FLAGS_MASK = 8'hBD;
    localparam logic [7:0] FLAGS_RST = 8'h80;
    localparam logic [7:0] ESE_RST = 8'h00;
    localparam logic [15:0] GRP_MASK = 16'h7FFF;
    localparam logic [15:0] PTR_DFLT = 16'h7FFF;
    localparam logic [15:0] NTR_DFLT = 16'h0000;
    localparam logic [15:0] EN_RST = 16'h0000;
    // ---------------------------------------------------------------
    // error code classes
    // ---------------------------------------------------------------
    localparam logic signed [15:0] QUERY_LO = -16'sd499;
    localparam logic signed [15:0] QUERY_HI = -16'sd400;
    localparam logic signed [15:0] DEVICE_LO = -16'sd399;
    localparam logic signed [15:0] DEVICE_HI = -16'sd300;
    localparam logic signed [15:0] DEVICE_POS = 16'sd2000;
    localparam logic signed [15:0] RUN_LO = -16'sd299;
    localparam logic signed [15:0] RUN_HI = -16'sd200;
    localparam logic signed [15:0] CMDERR_LO = -16'sd199;
    localparam logic signed [15:0] CMDERR_HI = -16'sd100;
    // ---------------------------------------------------------------
    // controller commands
    // ---------------------------------------------------------------
    typedef enum logic [4:0] {
        CMD_FLAGS_RD, CMD_ESE_WR, CMD_ESE_RD, CMD_CLS, CMD_DONE, CMD_PRESET,
        CMD_OP_COND_RD, CMD_OP_EV_RD, CMD_OP_PTR_WR, CMD_OP_PTR_RD,
        CMD_OP_NTR_WR, CMD_OP_NTR_RD, CMD_OP_EN_WR, CMD_OP_EN_RD,
        CMD_QS_COND_RD, CMD_QS_EV_RD, CMD_QS_PTR_WR, CMD_QS_PTR_RD,
        CMD_QS_NTR_WR, CMD_QS_NTR_RD, CMD_QS_EN_WR, CMD_QS_EN_RD
    } ser_cmd_e;
endpackage

/* File: verif/ser_host_model.sv */
/*
 * controlling computer model: issues one command per call on the block's
 * command port and collects the one-cycle answer.
 * assumes answers come on the same edge that takes the command, read 1ns later.
 */
`timescale 1ns/1ns

module ser_host_model (
    // clock
    input wire logic mclk,
    // command side
    output logic cmdValid,
    output ser_pkg::ser_cmd_e cmdCode,
    output logic [15:0] cmdData,
    // answer side
    input wire logic rspValid,
    input wire logic [15:0] rspData
);
    // ---------------------------------------------------------------
    // idle state at time zero
    // ---------------------------------------------------------------
    initial begin
        cmdValid = 1'b0;
        cmdCode = ser_pkg::CMD_FLAGS_RD;
        cmdData = 16'h0000;
    end

    // one command; reads clear flags and events, mask writes set masks
    task automatic xfer(input ser_pkg::ser_cmd_e c, input logic [15:0] d,
                        output logic [15:0] r, output logic ok);
        @(posedge mclk);
        cmdValid <= 1'b1;
        cmdCode <= c;
        cmdData <= d;
        @(posedge mclk);
        cmdValid <= 1'b0;
        cmdData <= ~d; // released data does not hold its value
        #1;
        ok = (rspValid === 1'b1);
        r = rspData;
    endtask
endmodule

/* File: verif/tb_top.sv */
/*
 * self-checking bench for the status event block: command sequences
 * with expected answers and summary bits.
 * assumes the host model in its own file and the block's command encoding.
 */
`timescale 1ns/1ns

`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; \
    $display("Error t=%0t got %0h exp %0h", $time, a, b); end end

module tb_top;
    // ---------------------------------------------------------------
    // signals
    // ---------------------------------------------------------------
    logic mclk = 1'b0, sys_rst = 1'b1, cmdValid, rspValid;
    logic [15:0] cmdData, rspData;
    ser_pkg::ser_cmd_e cmdCode;
    logic autoTrig = 1'b0, stats = 1'b0, mStart = 1'b0, mEnd = 1'b0;
    logic bStart = 1'b0, bLast = 1'b0, errValid = 1'b0;
    logic signed [15:0] errCode = 16'h0000;
    logic [6:0] evp = 7'h00;
    logic [15:0] cnd [2] = '{16'h0000, 16'h0000};
    logic qSum, eSum, oSum, pending;
    int n_errors = 0, n_checks = 0;
    logic signed [15:0] codes [7] = '{-16'sd410, -16'sd499, -16'sd300, 16'sd2000,
        -16'sd200, -16'sd299, -16'sd150};
    logic [7:0] codeExp [7] = '{8'h04, 8'h04, 8'h08, 8'h08, 8'h10, 8'h10, 8'h20};
    logic [7:0] evExp [7] = '{8'h04, 8'h04, 8'h20, 8'h20, 8'h20, 8'h08, 8'h10};

    always #20 mclk = ~mclk;

    // ---------------------------------------------------------------
    // design and host
    // ---------------------------------------------------------------
    ser_status_event u_dut (.mclk(mclk), .sys_rst(sys_rst), .ce(1'b1),
        .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdData(cmdData), .rspValid(rspValid),
        .rspData(rspData), .autoTrigCount(autoTrig), .statsEnable(stats),
        .totalizeOrPeaks(1'b0), .measStart(mStart), .measCycleEnd(mEnd),
        .blockStart(bStart), .blockLastDone(bLast), .errValid(errValid),
        .errCode(errCode), .queueEmptyRead(evp[0]), .queueDataLost(evp[1]),
        .syntaxError(evp[2]), .unknownCommand(evp[3]), .triggerInMessage(evp[4]),
        .internalFault(evp[5]), .paramError(evp[6]), .operCondIn(cnd[0]),
        .quesCondIn(cnd[1]), .questionable_summary(qSum),
        .standard_event_summary(eSum), .operation_summary(oSum), .pending(pending));
    ser_host_model u_host (.mclk(mclk), .cmdValid(cmdValid), .cmdCode(cmdCode),
        .cmdData(cmdData), .rspValid(rspValid), .rspData(rspData));

    // ---------------------------------------------------------------
    // access and closing tasks
    // ---------------------------------------------------------------
    task automatic acc(input ser_pkg::ser_cmd_e c, input logic [15:0] d, input logic [15:0] e);
        logic [15:0] r;
        logic ok;
        u_host.xfer(c, d, r, ok);
        `CHK({ok, r}, {1'b1, e})
    endtask

    task automatic grp(input int g, input int k, input logic [15:0] d, input logic [15:0] e);
        acc(ser_pkg::ser_cmd_e'(int'(ser_pkg::CMD_OP_COND_RD) + 8 * g + k), d, e);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic stop_test;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // watchdog against a hang
    initial begin
        tick(20000);
        n_errors++;
        stop_test();
    end

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        tick(10);
        sys_rst <= 1'b0;
        // reset values and read-clear
        acc(ser_pkg::CMD_FLAGS_RD, 16'h0000, 16'h0080);
        acc(ser_pkg::CMD_FLAGS_RD, 16'h0000, 16'h0000);
        acc(ser_pkg::CMD_ESE_RD, 16'h0000, 16'h0000);
        for (int g = 0; g < 2; g++) begin
            grp(g, 3, 16'h0000, 16'h7FFF);
            grp(g, 5, 16'h0000, 16'h0000);
            grp(g, 7, 16'h0000, 16'h0000);
        end
        $display("test reset done");
        // every error class and every event source
        for (int i = 0; i < 7; i++) begin
            errValid <= 1'b1;
            errCode <= codes[i];
            tick(1);
            errValid <= 1'b0;
            acc(ser_pkg::CMD_FLAGS_RD, 16'h0000, {8'h00, codeExp[i]});
            evp <= 7'(1 << i);
            tick(1);
            evp <= 7'h00;
            acc(ser_pkg::CMD_FLAGS_RD, 16'h0000, {8'h00, evExp[i]});
        end
        $display("test errors done");
        // summary through the mask, cleared by clear-status
        acc(ser_pkg::CMD_ESE_WR, 16'hFF04, 16'h0000);
        acc(ser_pkg::CMD_ESE_RD, 16'h0000, 16'h0004);
        evp <= 7'h04;
        tick(1);
        evp <= 7'h00;
        tick(3);
        `CHK(eSum, 1'b0)
        evp <= 7'h01;
        tick(1);
        evp <= 7'h00;
        tick(3);
        `CHK(eSum, 1'b1)
        acc(ser_pkg::CMD_CLS, 16'h0000, 16'h0000);
        tick(2);
        `CHK(eSum, 1'b0)
        acc(ser_pkg::CMD_FLAGS_RD, 16'h0000, 16'h0000);
        $display("test summary done");
        // operation complete, single and block modes
        acc(ser_pkg::CMD_DONE, 16'h0000, 16'h0000);
        acc(ser_pkg::CMD_FLAGS_RD, 16'h0000, 16'h0001);
        for (int m = 0; m < 2; m++) begin
            autoTrig <= m[0];
            stats <= m[0];
            if (m == 0) mStart <= 1'b1; else bStart <= 1'b1;
            tick(1);
            {mStart, bStart} <= 2'b00;
            if (m == 1) mEnd <= 1'b1;
            tick(1);
            mEnd <= 1'b0;
            tick(1);
            `CHK(pending, 1'b1)
            acc(ser_pkg::CMD_DONE, 16'h0000, 16'h0000);
            acc(ser_pkg::CMD_FLAGS_RD, 16'h0000, 16'h0000);
            if (m == 0) mEnd <= 1'b1; else bLast <= 1'b1;
            tick(1);
            {mEnd, bLast} <= 2'b00;
            tick(1);
            `CHK(pending, 1'b0)
            acc(ser_pkg::CMD_FLAGS_RD, 16'h0000, 16'h0001);
        end
        $display("test pending done");
        // status groups: filters, sticky events, masks, preset
        for (int g = 0; g < 2; g++) begin
            grp(g, 2, 16'h8001, 16'h0000);
            grp(g, 4, 16'h0006, 16'h0000);
            grp(g, 6, 16'h0003, 16'h0000);
            cnd[g] <= 16'h8007;
            tick(6);
            `CHK({qSum, oSum}, g ? 2'b10 : 2'b01)
            grp(g, 0, 16'h0000, 16'h0007);
            grp(g, 0, 16'h0000, 16'h0007);
            cnd[g] <= 16'h0000;
            tick(6);
            grp(g, 1, 16'h0000, 16'h0007);
            grp(g, 1, 16'h0000, 16'h0000);
            cnd[g] <= 16'h0001;
            tick(6);
            acc(ser_pkg::CMD_CLS, 16'h0000, 16'h0000);
            grp(g, 1, 16'h0000, 16'h0000);
            grp(g, 3, 16'h0000, 16'h0001);
            acc(ser_pkg::CMD_PRESET, 16'h0000, 16'h0000);
            grp(g, 3, 16'h0000, 16'h7FFF);
            grp(g, 5, 16'h0000, 16'h0000);
            grp(g, 7, 16'h0000, 16'h0000);
            cnd[g] <= 16'h0000;
            tick(6);
            grp(g, 1, 16'h0000, 16'h0000);
        end
        $display("test groups done");
        stop_test();
    end
endmodule
